// *** hdl/iep_pkg.sv ***
// Constants, types and decode helpers of the interrupt enable and priority block.
// Assumes a single 50 MHz core clock and a byte-wide special register port from the core.
//
// What this block does
// R01 - Enable bit 7 blocks every source when clear; when set, each source follows its bit.
// R02 - Enable bit 6 lets the converter request through when one, blocks it when zero.
// R03 - Enable bit 5 lets the third timer request through when one, masks it when zero.
// R04 - Enable bit 4 lets the serial port request through when one, masks it when zero.
// R05 - Enable bit 3 lets the second timer overflow through when one, masks it when zero.
// R06 - Enable bit 2 lets the second pin flag through when one, masks it when zero.
// R07 - Enable bit 1 lets the first timer overflow through when one, masks it when zero.
// R08 - Enable bit 0 lets the first pin flag through when one, masks it when zero.
// R09 - Priority bit 7 is not implemented; writes are ignored and it holds no state.
// R10 - Priority bit 6 puts the converter at high level when one, low when zero.
// R11 - Priority bit 5 puts the third timer at high level when one, low when zero.
// R12 - Priority bit 4 puts the serial port at high level when one, low when zero.
// R13 - Priority bit 3 puts the second timer at high level when one, low when zero.
// R14 - Priority bit 2 puts the second pin at high level when one, low when zero.
// R15 - Priority bit 1 puts the first timer at high level when one, low when zero.
// R16 - Priority bit 0 puts the first pin at high level when one, low when zero.
// R17 - Sources are handled at two priority levels; the priority register sets the level of each.
// R18 - Timer overflow flags are set by hardware and cleared when the core vectors.
// R19 - Pin flags clear on vectoring only in edge mode; in level mode they follow the pin.
// R20 - The enable register resets to zero and can be written one bit at a time.
// R21 - High preempts low service; low never preempts high; equal levels wait for return.

////////////////////////////////////////////////////////////////////////////////////////////////////

package iep_pkg;

   localparam int unsigned IEP_NSRC = 7;

   typedef logic [IEP_NSRC-1:0] iep_src_vec_t;
   typedef logic [2:0]          iep_src_idx_t;
   typedef logic [7:0]          iep_byte_t;

   // Register addresses on the core's special register port.
   localparam iep_byte_t IEP_ENABLE_ADDR   = 8'hA8;
   localparam iep_byte_t IEP_PRIORITY_ADDR = 8'hB8;
   localparam iep_byte_t IEP_ENABLE_RESET   = 8'h00;
   localparam iep_byte_t IEP_PRIORITY_RESET = 8'h00;
   localparam iep_byte_t IEP_PRIORITY_MASK  = 8'h7F;
   localparam iep_byte_t IEP_UNMAPPED_READ  = 8'h00;

   // Source index equals the bit position of its enable and priority bits.
   localparam int unsigned IEP_SRC_FIRST_PIN    = 0;
   localparam int unsigned IEP_SRC_FIRST_TIMER  = 1;
   localparam int unsigned IEP_SRC_SECOND_PIN   = 2;
   localparam int unsigned IEP_SRC_SECOND_TIMER = 3;
   localparam int unsigned IEP_SRC_SERIAL       = 4;
   localparam int unsigned IEP_SRC_THIRD_TIMER  = 5;
   localparam int unsigned IEP_SRC_CONVERTER    = 6;
   localparam int unsigned IEP_GLOBAL_BIT       = 7;

   // Positions of the two service levels in the in-service vector.
   localparam int unsigned IEP_SVC_LOW  = 0;
   localparam int unsigned IEP_SVC_HIGH = 1;

   // Bit addresses share the upper five bits with the byte address of their register.
   localparam int unsigned IEP_BIT_SEL_W = 3;

   function automatic logic iep_bit_hit(input iep_byte_t bit_addr, input iep_byte_t base);
      iep_bit_hit = (bit_addr[7:IEP_BIT_SEL_W] == base[7:IEP_BIT_SEL_W]);
   endfunction

   function automatic iep_src_vec_t iep_onehot(input iep_src_idx_t idx);
      iep_src_vec_t v;
      v = '0;
      v[idx] = 1'b1;
      iep_onehot = v;
   endfunction

endpackage

// *** hdl/iep_pick_if.sv ***
// Carrier between the main block and its fixed-order request picker.
// Assumes both ends sit in the same clock domain; the picker is purely combinational.

////////////////////////////////////////////////////////////////////////////////////////////////////

interface iep_pick_if;
   iep_pkg::iep_src_vec_t req;
   logic                  valid;
   iep_pkg::iep_src_idx_t idx;

   modport picker (
      input  req,
      output valid,
      output idx
   );

   modport user (
      output req,
      input  valid,
      input  idx
   );
endinterface

// *** hdl/iep_picker.sv ***
// Fixed polling-order picker for one priority level.
// Assumes the request vector is already gated by enables and level; lowest index wins.

////////////////////////////////////////////////////////////////////////////////////////////////////

module iep_picker (
   iep_pick_if.picker pick
);

   always_comb begin
      pick.valid = 1'b0;
      pick.idx   = '0;
      // Scanning downward lets the lowest pending index overwrite the rest.
      for (int i = iep_pkg::IEP_NSRC - 1; i >= 0; i--) begin
         if (pick.req[i]) begin
            pick.valid = 1'b1;
            pick.idx   = iep_pkg::iep_src_idx_t'(i);
         end
      end
   end

endmodule

// *** hdl/iep_top.sv ***
// Interrupt enable and priority logic facing the processor core.
// Assumes peripheral request inputs come from logic on clk_sys_in; the two external request
// pins are asynchronous and active low. The core pulses irq_ack_in when it vectors to the
// presented source and irq_return_in when a service routine returns.

////////////////////////////////////////////////////////////////////////////////////////////////////

module iep_top (
   input  wire logic              clk_sys_in,
   input  wire logic              reset_n_in,
   input  wire logic [7:0]        sfr_addr_in,
   input  wire logic              sfr_wr_in,
   input  wire logic [7:0]        sfr_wdata_in,
   input  wire logic              sfr_rd_in,
   output logic      [7:0]        sfr_rdata_out,
   input  wire logic              sfr_bit_wr_in,
   input  wire logic [7:0]        sfr_bit_addr_in,
   input  wire logic              sfr_bit_value_in,
   input  wire logic              first_timer_overflow_in,
   input  wire logic              second_timer_overflow_in,
   input  wire logic              third_timer_req_in,
   input  wire logic              serial_port_req_in,
   input  wire logic              converter_req_in,
   input  wire logic              first_external_request_pin_n_in,
   input  wire logic              second_external_request_pin_n_in,
   input  wire logic              first_pin_edge_mode_in,
   input  wire logic              second_pin_edge_mode_in,
   input  wire logic              irq_ack_in,
   input  wire logic              irq_return_in,
   output logic                   irq_req_out,
   output logic      [2:0]        irq_src_out,
   output logic                   irq_high_out,
   output logic                   first_timer_overflow_flag_out,
   output logic                   second_timer_overflow_flag_out,
   output logic                   first_pin_request_flag_out,
   output logic                   second_pin_request_flag_out,
   output logic      [1:0]        in_service_out
);

   ////////////////////////////////////////////////////////////////////////////////////////////////////
   // Local constants and the vectoring decode.

   localparam int unsigned      NPIN    = 2;
   localparam int unsigned      NTMR    = 2;
   localparam int unsigned      FIRST   = 0;
   localparam int unsigned      SECOND  = 1;
   localparam int unsigned      SEL_W   = iep_pkg::IEP_BIT_SEL_W;
   localparam int unsigned      NSRC    = iep_pkg::IEP_NSRC;
   localparam logic [SEL_W-1:0] TOP_SEL = iep_pkg::IEP_GLOBAL_BIT[SEL_W-1:0];

   // True when the core takes the presented vector and that vector belongs to source mine.
   function automatic logic vectored_to(input logic                  take,
                                        input iep_pkg::iep_src_idx_t presented,
                                        input int unsigned           mine);
      vectored_to = take && (presented == iep_pkg::iep_src_idx_t'(mine));
   endfunction

   ////////////////////////////////////////////////////////////////////////////////////////////////////
   // Declarations.

   iep_pkg::iep_byte_t    enable_r;
   iep_pkg::iep_byte_t    enable_nxt;
   iep_pkg::iep_src_vec_t priority_r;
   iep_pkg::iep_src_vec_t priority_nxt;
   iep_pkg::iep_byte_t    rdata_r;
   iep_pkg::iep_byte_t    rdata_nxt;
   logic [SEL_W-1:0]      bit_sel;
   logic                  enable_byte_hit;
   logic                  enable_bit_hit;
   logic                  priority_byte_hit;
   logic                  priority_bit_hit;
   logic [NPIN-1:0]       pin_n_raw;
   logic [NPIN-1:0]       pin_edge_mode;
   logic [NPIN-1:0]       pin_meta_r;
   logic [NPIN-1:0]       pin_meta_nxt;
   logic [NPIN-1:0]       pin_sync_r;
   logic [NPIN-1:0]       pin_sync_nxt;
   logic [NPIN-1:0]       pin_prev_r;
   logic [NPIN-1:0]       pin_prev_nxt;
   logic [NPIN-1:0]       pin_fall;
   logic [NPIN-1:0]       pin_flag_r;
   logic [NPIN-1:0]       pin_flag_nxt;
   logic [NTMR-1:0]       tmr_ovf;
   logic [NTMR-1:0]       tmr_flag_r;
   logic [NTMR-1:0]       tmr_flag_nxt;
   iep_pkg::iep_src_vec_t src_flag;
   iep_pkg::iep_src_vec_t src_pend;
   iep_pkg::iep_src_vec_t high_vec;
   iep_pkg::iep_src_vec_t low_vec;
   logic                  ack_take;
   logic                  irq_req_r;
   logic                  irq_req_nxt;
   iep_pkg::iep_src_idx_t irq_src_r;
   iep_pkg::iep_src_idx_t irq_src_nxt;
   logic                  irq_high_r;
   logic                  irq_high_nxt;
   logic [1:0]            in_service_r;
   logic [1:0]            in_service_nxt;

   ////////////////////////////////////////////////////////////////////////////////////////////////////
   // Enable and priority registers, written by byte or by single bit.

   assign bit_sel           = sfr_bit_addr_in[SEL_W-1:0];
   assign enable_byte_hit   = sfr_wr_in && (sfr_addr_in == iep_pkg::IEP_ENABLE_ADDR);
   assign priority_byte_hit = sfr_wr_in && (sfr_addr_in == iep_pkg::IEP_PRIORITY_ADDR);
   assign enable_bit_hit    = sfr_bit_wr_in && iep_pkg::iep_bit_hit(sfr_bit_addr_in, iep_pkg::IEP_ENABLE_ADDR);
   assign priority_bit_hit  = sfr_bit_wr_in && iep_pkg::iep_bit_hit(sfr_bit_addr_in, iep_pkg::IEP_PRIORITY_ADDR);

   always_comb begin
      enable_nxt   = enable_r;
      priority_nxt = priority_r;
      if (enable_byte_hit) begin
         enable_nxt = sfr_wdata_in;
      end else if (enable_bit_hit) begin
         enable_nxt[bit_sel] = sfr_bit_value_in;   // R20
      end
      // The top priority bit has no flop behind it, so writes to it simply vanish.
      if (priority_byte_hit) begin
         priority_nxt = sfr_wdata_in[NSRC-1:0];   // R09
      end else if (priority_bit_hit && (bit_sel != TOP_SEL)) begin
         priority_nxt[bit_sel] = sfr_bit_value_in;   // R09
      end
   end

   always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         enable_r   <= iep_pkg::IEP_ENABLE_RESET;   // R20
         priority_r <= iep_pkg::IEP_PRIORITY_RESET[NSRC-1:0];
      end else begin
         enable_r   <= enable_nxt;
         priority_r <= priority_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////////////
   // Read data is registered and stands from the cycle after the read strobe.

   always_comb begin
      rdata_nxt = rdata_r;
      if (sfr_rd_in) begin
         case (sfr_addr_in)
            iep_pkg::IEP_ENABLE_ADDR:   rdata_nxt = enable_r;
            iep_pkg::IEP_PRIORITY_ADDR: rdata_nxt = {1'b0, priority_r} & iep_pkg::IEP_PRIORITY_MASK;   // R09
            default:                    rdata_nxt = iep_pkg::IEP_UNMAPPED_READ;
         endcase
      end
   end

   always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         rdata_r <= iep_pkg::IEP_UNMAPPED_READ;
      end else begin
         rdata_r <= rdata_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////////////
   // External request pins: a two-flop synchroniser, then one history flop for edges.

   assign pin_n_raw     = {second_external_request_pin_n_in, first_external_request_pin_n_in};
   assign pin_edge_mode = {second_pin_edge_mode_in, first_pin_edge_mode_in};
   assign pin_fall      = pin_prev_r & ~pin_sync_r;

   always_comb begin
      pin_meta_nxt = pin_n_raw;
      pin_sync_nxt = pin_meta_r;
      pin_prev_nxt = pin_sync_r;
   end

   // Resetting to the idle high level keeps a false falling edge from following reset.
   always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         pin_meta_r <= '1;
         pin_sync_r <= '1;
         pin_prev_r <= '1;
      end else begin
         pin_meta_r <= pin_meta_nxt;
         pin_sync_r <= pin_sync_nxt;
         pin_prev_r <= pin_prev_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////////////
   // Request flags. A new event in the cycle of vectoring wins over the clear, so none is lost.

   for (genvar g = 0; g < NPIN; g++) begin : g_pin_flag
      localparam int unsigned SRC = (g == FIRST) ? iep_pkg::IEP_SRC_FIRST_PIN : iep_pkg::IEP_SRC_SECOND_PIN;
      // In level mode the flag mirrors the pin, and vectoring cannot clear it.
      assign pin_flag_nxt[g] = pin_edge_mode[g]
                             ? (pin_fall[g] || (pin_flag_r[g] && !vectored_to(ack_take, irq_src_r, SRC)))
                             : !pin_sync_r[g];   // R19
   end

   assign tmr_ovf = {second_timer_overflow_in, first_timer_overflow_in};

   for (genvar g = 0; g < NTMR; g++) begin : g_tmr_flag
      localparam int unsigned SRC = (g == FIRST) ? iep_pkg::IEP_SRC_FIRST_TIMER : iep_pkg::IEP_SRC_SECOND_TIMER;
      assign tmr_flag_nxt[g] = tmr_ovf[g] || (tmr_flag_r[g] && !vectored_to(ack_take, irq_src_r, SRC));   // R18
   end

   always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         pin_flag_r <= '0;
         tmr_flag_r <= '0;
      end else begin
         pin_flag_r <= pin_flag_nxt;
         tmr_flag_r <= tmr_flag_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////////////
   // Source vector, gating and split into the two levels.

   // The converter, serial port and third timer keep their own flags; their requests arrive as levels.
   always_comb begin
      src_flag                                = '0;
      src_flag[iep_pkg::IEP_SRC_FIRST_PIN]    = pin_flag_r[FIRST];
      src_flag[iep_pkg::IEP_SRC_FIRST_TIMER]  = tmr_flag_r[FIRST];
      src_flag[iep_pkg::IEP_SRC_SECOND_PIN]   = pin_flag_r[SECOND];
      src_flag[iep_pkg::IEP_SRC_SECOND_TIMER] = tmr_flag_r[SECOND];
      src_flag[iep_pkg::IEP_SRC_SERIAL]       = serial_port_req_in;
      src_flag[iep_pkg::IEP_SRC_THIRD_TIMER]  = third_timer_req_in;
      src_flag[iep_pkg::IEP_SRC_CONVERTER]    = converter_req_in;
   end

   assign src_pend = src_flag & enable_r[NSRC-1:0]   // R02 R03 R04 R05 R06 R07 R08
                   & {NSRC{enable_r[iep_pkg::IEP_GLOBAL_BIT]}};   // R01
   assign high_vec = src_pend & priority_r;    // R10 R11 R12 R13 R14 R15 R16
   assign low_vec  = src_pend & ~priority_r;   // R10 R11 R12 R13 R14 R15 R16

   ////////////////////////////////////////////////////////////////////////////////////////////////////
   // One fixed-order picker per level.

   iep_pick_if high_pick ();
   iep_pick_if low_pick ();

   assign high_pick.req = high_vec;   // R17
   assign low_pick.req  = low_vec;    // R17

   iep_picker i_high_picker (
      .pick (high_pick)
   );

   iep_picker i_low_picker (
      .pick (low_pick)
   );

   ////////////////////////////////////////////////////////////////////////////////////////////////////
   // Presentation to the core and nesting of services.

   assign ack_take = irq_ack_in && irq_req_r;

   // The request drops for the cycle after vectoring, so the core never sees a stale vector
   // while the service and flag state catch up.
   always_comb begin
      irq_req_nxt  = 1'b0;
      irq_src_nxt  = irq_src_r;
      irq_high_nxt = irq_high_r;
      if (ack_take) begin
         irq_req_nxt = 1'b0;
      end else if (high_pick.valid && !in_service_r[iep_pkg::IEP_SVC_HIGH]) begin
         irq_req_nxt  = 1'b1;   // R21
         irq_src_nxt  = high_pick.idx;
         irq_high_nxt = 1'b1;
      end else if (low_pick.valid && (in_service_r == '0)) begin
         irq_req_nxt  = 1'b1;   // R21
         irq_src_nxt  = low_pick.idx;
         irq_high_nxt = 1'b0;
      end
   end

   always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         irq_req_r  <= 1'b0;
         irq_src_r  <= '0;
         irq_high_r <= 1'b0;
      end else begin
         irq_req_r  <= irq_req_nxt;
         irq_src_r  <= irq_src_nxt;
         irq_high_r <= irq_high_nxt;
      end
   end

   // A return closes the innermost service: the high one if active, otherwise the low one.
   always_comb begin
      in_service_nxt = in_service_r;
      if (irq_return_in) begin
         if (in_service_r[iep_pkg::IEP_SVC_HIGH]) begin
            in_service_nxt[iep_pkg::IEP_SVC_HIGH] = 1'b0;
         end else begin
            in_service_nxt[iep_pkg::IEP_SVC_LOW] = 1'b0;
         end
      end
      if (ack_take) begin
         if (irq_high_r) begin
            in_service_nxt[iep_pkg::IEP_SVC_HIGH] = 1'b1;   // R21
         end else begin
            in_service_nxt[iep_pkg::IEP_SVC_LOW] = 1'b1;    // R21
         end
      end
   end

   always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         in_service_r <= '0;
      end else begin
         in_service_r <= in_service_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////////////
   // Outputs, each straight from a flop.

   assign sfr_rdata_out                  = rdata_r;
   assign irq_req_out                    = irq_req_r;
   assign irq_src_out                    = irq_src_r;
   assign irq_high_out                   = irq_high_r;
   assign first_timer_overflow_flag_out  = tmr_flag_r[FIRST];
   assign second_timer_overflow_flag_out = tmr_flag_r[SECOND];
   assign first_pin_request_flag_out     = pin_flag_r[FIRST];
   assign second_pin_request_flag_out    = pin_flag_r[SECOND];
   assign in_service_out                 = in_service_r;

endmodule

// *** testbench/iep_monitor.sv ***
// Checker bound to the interrupt enable and priority top.
// Assumes bit 0 of in_service_out marks low level service and bit 1 high level service.
module iep_monitor (
   input wire logic       clk_sys_in, reset_n_in, irq_ack_in, irq_req_out, irq_high_out, first_pin_edge_mode_in,
   input wire logic       first_timer_overflow_in, second_timer_overflow_in, first_timer_overflow_flag_out,
   input wire logic       second_timer_overflow_flag_out, first_pin_request_flag_out,
   input wire logic [2:0] irq_src_out,
   input wire logic [1:0] in_service_out);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (!reset_n_in);
   property p_src; irq_req_out |-> irq_src_out < 3'h7; endproperty
   a_src: assert property (p_src) else $error("source index out of range");
   property p_t0clr;
      irq_ack_in && irq_req_out && irq_src_out == 3'h1 && !first_timer_overflow_in |=> !first_timer_overflow_flag_out;
   endproperty
   a_t0clr: assert property (p_t0clr) else $error("first timer flag kept after vectoring");
   property p_t1clr;
      irq_ack_in && irq_req_out && irq_src_out == 3'h3 && !second_timer_overflow_in |=> !second_timer_overflow_flag_out;
   endproperty
   a_t1clr: assert property (p_t1clr) else $error("second timer flag kept after vectoring");
   property p_t0hold; first_timer_overflow_flag_out && !irq_ack_in |=> first_timer_overflow_flag_out; endproperty
   a_t0hold: assert property (p_t0hold) else $error("first timer flag lost");
   property p_t1hold; second_timer_overflow_flag_out && !irq_ack_in |=> $stable(second_timer_overflow_flag_out); endproperty
   a_t1hold: assert property (p_t1hold) else $error("second timer flag lost");
   property p_pinclr;
      irq_ack_in && irq_req_out && irq_src_out == 3'h0 && first_pin_edge_mode_in |=> !first_pin_request_flag_out;
   endproperty
   a_pinclr: assert property (p_pinclr) else $error("edge pin flag kept after vectoring");
   property p_preempt; irq_req_out && in_service_out[0] |-> irq_high_out; endproperty
   a_preempt: assert property (p_preempt) else $error("low request during low service");
   property p_block; in_service_out[1] |-> !irq_req_out; endproperty
   a_block: assert property (p_block) else $error("request during high service");
   c_high: cover property (irq_ack_in && irq_high_out);
   c_low: cover property (irq_ack_in && !irq_high_out);
   c_pin: cover property (first_pin_request_flag_out);
endmodule
bind iep_top iep_monitor i_iep_monitor (.*);

// *** testbench/iep_core_model.sv ***
// Core model: vectors to each presented request, then returns seven cycles later.
// Assumes one service at a time; it never nests.
module iep_core_model (
   input  wire logic clk_sys_in, reset_n_in, irq_req_in,
   output logic      ack_out, ret_out);
   timeunit 1ns;
   timeprecision 1ns;
   int cnt;
   always @(posedge clk_sys_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         cnt <= 0;
         ack_out <= 1'b0;
         ret_out <= 1'b0;
      end else begin
         ack_out <= irq_req_in && cnt == 0 && !ack_out && !ret_out;
         cnt <= ack_out ? 1 : (cnt == 6 ? 0 : (cnt > 0 ? cnt + 1 : 0));
         ret_out <= cnt == 6;
      end
   end
endmodule

// *** testbench/iep_tb_top.sv ***
// Testbench of the interrupt enable and priority block.
// Assumes edge mode on both pins and read data valid one cycle after the read strobe.
module iep_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_sys_in = 0, reset_n_in = 0, wr = 0, rd = 0, bwr = 0, ack, ret, req, high, pf2;
   logic [7:0] addr = 0, wdata = 0, baddr = 0, rdata;
   logic [6:0] src = 0;
   logic [2:0] sidx;
   int n_fail = 0, n_compared = 0;
   iep_top i_iep_top (.clk_sys_in, .reset_n_in, .sfr_addr_in(addr), .sfr_wr_in(wr), .sfr_wdata_in(wdata),
      .sfr_rd_in(rd), .sfr_rdata_out(rdata), .sfr_bit_wr_in(bwr), .sfr_bit_addr_in(baddr), .sfr_bit_value_in(wdata[0]),
      .first_timer_overflow_in(src[1]), .second_timer_overflow_in(src[3]), .third_timer_req_in(src[5]),
      .serial_port_req_in(src[4]), .converter_req_in(src[6]), .first_external_request_pin_n_in(~src[0]),
      .second_external_request_pin_n_in(~src[2]), .first_pin_edge_mode_in(1'b1), .second_pin_edge_mode_in(1'b1),
      .irq_ack_in(ack), .irq_return_in(ret), .irq_req_out(req), .irq_src_out(sidx), .irq_high_out(high),
      .first_timer_overflow_flag_out(), .second_timer_overflow_flag_out(), .first_pin_request_flag_out(),
      .second_pin_request_flag_out(pf2), .in_service_out());
   iep_core_model i_iep_core_model (.clk_sys_in, .reset_n_in, .irq_req_in(req), .ack_out(ack), .ret_out(ret));
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_fail++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wreg(input logic [7:0] a, input logic [7:0] d, input logic b);
      @(negedge clk_sys_in) {addr, baddr, wdata, wr, bwr} = {a, a, d, !b, b};
      @(negedge clk_sys_in) {wr, bwr} = 2'b00;
   endtask
   task automatic rreg(input logic [7:0] a, input logic [7:0] exp);
      @(negedge clk_sys_in) {addr, rd} = {a, 1'b1};
      @(negedge clk_sys_in) chk(rdata, exp);
      rd = 0;
   endtask
   task automatic take(input logic [7:0] exp);
      for (int k = 0; k < 30 && !ack; k++) @(negedge clk_sys_in);
      chk({ack, high, 3'h0, sidx}, exp);
      src = 0;
      repeat (12) @(negedge clk_sys_in);
   endtask
   task automatic wrap_up;
      $display("compared %0d mismatches %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   initial forever #10 clk_sys_in = ~clk_sys_in;
   initial begin
      #100us n_fail++;
      wrap_up;
   end
   initial begin
      repeat (4) @(negedge clk_sys_in);
      reset_n_in = 1;
      rreg(8'hA8, 8'h00);
      rreg(8'hB8, 8'h00);
      wreg(8'hB8, 8'hD5, 1'b0);
      rreg(8'hB8, 8'h55);
      $display("register test done");
      for (int i = 0; i < 7; i++) begin
         wreg(8'hA8, 8'h80 | (8'h01 << i), 1'b0);
         src = 7'h01 << i;
         take({1'b1, 1'((8'h55 >> i) & 8'h01), 3'h0, 3'(i)});
      end
      $display("source test done");
      wreg(8'hA8, 8'h7F, 1'b0);
      src = 7'h7F;
      repeat (10) @(negedge clk_sys_in);
      chk({7'h0, req}, 8'h00);
      chk({7'h0, pf2}, 8'h01);
      wreg(8'hAF, 8'h01, 1'b1);
      take(8'hC0);
      $display("gate test done");
      wrap_up;
   end
endmodule
